// ===== verilog/ssd_sequencer.sv
// ssd_sequencer: 16-step, 16-output step sequencer drum, AHB-Lite slave.
// assumes one clock, pins synchronised here, ladder drives ctrl register.
// How it works
// [R1] start acts only with reset off; runs timer or waits for event
// [R2] start off with reset off freezes step, timer and outputs
// [R3] each jog rising edge advances one step, start on or off
// [R4] the purely timed variant has no jog
// [R5] reset beats start; holds preset step, no timing, no events
// [R6] preset step 1..16, entered on reset and on non-retentive run entry
// [R7] each step has its own count target, optional on event variants
// [R8] each step has its own selectable event, optional on event variants
// [R9] four status counters: count, timer, preset, current step
// [R10] outputs written whenever run mode is on, preset pattern at non-retentive entry
// [R11] non-retentive entry zeroes counts, sets steps to preset
// [R12] retentive entry keeps all four counters
// [R13] retentive is the default
// [R14] only the two masked variants apply the write mask
// [R15] masked variants use one 16-bit mask word per step
// [R16] mask bit 1 writes pattern bit, 0 keeps output as is
// [R17] last step done sets done flag, step stays at last
// [R18] reset clears done flag and forces preset step
// [R19] jog clears the timer; with start on the new step runs at once
// [R20] jog in the last step moves to drum complete
// [R21] timer counts only while event true; target reached moves on
// [R22] step time is hundredth times timebase times count target
// [R23] when complete, start and jog are ignored until reset or non-retentive entry
// [R24] step logic and outputs are evaluated once per scan tick
// [R25] timer counts hundredths; count in step bumps at timebase
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module ssd_sequencer #(
  parameter ssd_pkg::ssd_variant_t VARIANT = ssd_pkg::SSD_MASKED_WORD,
  parameter int unsigned           TICK_N  = ssd_pkg::TICK_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   scan_tick,
  input  wire logic                   run_mode_pin,
  input  wire logic [ssd_pkg::OUTS-1:0] event_pin,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output logic [ssd_pkg::OUTS-1:0]    out_image,
  output logic                        cycle_done_flag
);
  import ssd_pkg::*;
  localparam logic HAS_EVENT = (VARIANT != SSD_TIMED); // [R4]
  localparam logic MASKED    = (VARIANT == SSD_MASKED_BITS) ||
                               (VARIANT == SSD_MASKED_WORD); // [R14]

  ssd_timer_if tif ();

  // pin synchronisers, change accepted when stages 2 and 3 agree
  localparam int unsigned NPIN = OUTS + 1;
  wire  [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] filt_q;
  assign pin_raw = {run_mode_pin, event_pin};
  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    logic [SYNC_N-1:0] s_q;
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        s_q       <= '0;
        filt_q[p] <= 1'h0;
      end else if (clk_en) begin
        s_q <= {s_q[SYNC_N-2:0], pin_raw[p]};
        if (s_q[1] == s_q[2]) begin
          filt_q[p] <= s_q[2];
        end
      end
    end
  end
  wire            run_f;
  wire [OUTS-1:0] ev_f;
  assign run_f = filt_q[OUTS];
  assign ev_f  = filt_q[OUTS-1:0];

  // registers
  logic [3:0]    ctrl_q;
  logic [SW-1:0] preset_q;
  logic [SW-1:0] cur_q;
  logic [SW-1:0] last_q;
  logic [CW-1:0] tbase_q;
  logic          done_q;
  logic          jog_prev_q;
  logic          run_seen_q;
  logic          tick_run_q;
  logic [OUTS-1:0] out_q;
  logic [OUTS-1:0] pat_q [STEPS];
  logic [CW-1:0]   cnt_q [STEPS];
  logic [EVT_EN:0] evt_q [STEPS];
  logic [OUTS-1:0] msk_q [STEPS];

  // bus slave: address phase capture, write in data phase
  logic          wr_pend_q;
  logic [AW-1:0] waddr_q;
  logic [31:0]   hrdata_q;
  wire           take;
  wire  [AW-1:0] a_now;
  assign take      = clk_en && hsel && hready && (htrans == HTRANS_NSEQ);
  assign a_now     = haddr[AW-1:0];
  assign hreadyout = clk_en;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_q;

  // read decode
  wire [IW-1:0] r_ix;
  wire          r_pat;
  wire          r_cnt;
  wire          r_evt;
  wire          r_msk;
  wire [CW-1:0] rd_word;
  assign r_ix  = a_now[IX_LSB +: IW];
  assign r_pat = a_now[AW-1:TAB_LSB] == TAB_PAT[AW-1:TAB_LSB];
  assign r_cnt = a_now[AW-1:TAB_LSB] == TAB_CNT[AW-1:TAB_LSB];
  assign r_evt = a_now[AW-1:TAB_LSB] == TAB_EVT[AW-1:TAB_LSB];
  assign r_msk = MASKED && a_now[AW-1:TAB_LSB] == TAB_MSK[AW-1:TAB_LSB];
  assign rd_word =
    (a_now == OFS_CTRL)   ? CW'(ctrl_q) :
    (a_now == OFS_STATUS) ? CW'({run_f, done_q}) :
    (a_now == OFS_CIS)    ? tif.cis : // [R9]
    (a_now == OFS_TMR)    ? tif.tmr :
    (a_now == OFS_PRESET) ? CW'(preset_q) :
    (a_now == OFS_CUR)    ? CW'(cur_q) :
    (a_now == OFS_TBASE)  ? tbase_q :
    (a_now == OFS_LAST)   ? CW'(last_q) :
    (a_now == OFS_OUT)    ? out_q :
    r_pat ? pat_q[r_ix] :
    r_cnt ? cnt_q[r_ix] :
    r_evt ? CW'(evt_q[r_ix]) :
    r_msk ? msk_q[r_ix] : '0;

  // write decode
  wire [IW-1:0] w_ix;
  wire          w_en;
  wire [SW-1:0] w_step;
  wire          w_step_ok;
  wire          w_ctrl;
  wire          w_preset;
  wire          w_cur;
  assign w_en      = wr_pend_q && clk_en;
  assign w_ix      = waddr_q[IX_LSB +: IW];
  assign w_step    = hwdata[SW-1:0];
  assign w_step_ok = (hwdata[CW-1:0] >= CW'(STEP_FIRST)) &&
                     (hwdata[CW-1:0] <= CW'(STEP_LAST)); // [R6]
  assign w_ctrl    = w_en && waddr_q == OFS_CTRL;
  assign w_preset  = w_en && waddr_q == OFS_PRESET && w_step_ok;
  assign w_cur     = w_en && waddr_q == OFS_CUR && w_step_ok;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'h0;
      waddr_q   <= '0;
      hrdata_q  <= '0;
    end else if (clk_en) begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        waddr_q  <= a_now;
        hrdata_q <= {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q  <= {RETAIN_RST, 3'h0}; // [R13]
      tbase_q <= TBASE_RST;
      last_q  <= STEP_LAST;
    end else if (w_en) begin
      if (waddr_q == OFS_CTRL) ctrl_q <= hwdata[3:0];
      if (waddr_q == OFS_TBASE) tbase_q <= hwdata[CW-1:0]; // [R22]
      if (waddr_q == OFS_LAST && w_step_ok) last_q <= w_step;
    end
  end

  // per-step tables, one word per step
  for (genvar s = 0; s < STEPS; s++) begin : g_tab
    wire hit;
    assign hit = w_en && w_ix == IW'(s);
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        pat_q[s] <= '0;
        cnt_q[s] <= '0;
        evt_q[s] <= '0;
        msk_q[s] <= '1;
      end else if (hit) begin
        if (waddr_q[AW-1:TAB_LSB] == TAB_PAT[AW-1:TAB_LSB])
          pat_q[s] <= hwdata[OUTS-1:0];
        if (waddr_q[AW-1:TAB_LSB] == TAB_CNT[AW-1:TAB_LSB])
          cnt_q[s] <= hwdata[CW-1:0]; // [R7]
        if (waddr_q[AW-1:TAB_LSB] == TAB_EVT[AW-1:TAB_LSB])
          evt_q[s] <= hwdata[EVT_EN:0]; // [R8]
        if (waddr_q[AW-1:TAB_LSB] == TAB_MSK[AW-1:TAB_LSB])
          msk_q[s] <= hwdata[OUTS-1:0]; // [R15]
      end
    end
  end

  // step evaluation
  wire          step_en;
  wire          entry;
  wire          start_c;
  wire          rst_c;
  wire          retain;
  wire [SW-1:0] cur_m1;
  wire [IW-1:0] cur_ix;
  wire          has_count;
  wire          ev_on;
  wire          ev_ok;
  wire          step_met;
  wire          jog_rise;
  wire          at_last;
  assign step_en   = clk_en && scan_tick; // [R24]
  assign entry     = run_f && !run_seen_q;
  assign start_c   = ctrl_q[CTRL_START];
  assign rst_c     = ctrl_q[CTRL_RESET];
  assign retain    = ctrl_q[CTRL_RETAIN];
  assign cur_m1    = cur_q - STEP_FIRST;
  assign cur_ix    = cur_m1[IW-1:0];
  assign has_count = cnt_q[cur_ix] != '0; // [R7]
  assign ev_on     = HAS_EVENT && evt_q[cur_ix][EVT_EN]; // [R8]
  assign ev_ok     = !ev_on || ev_f[evt_q[cur_ix][IW-1:0]]; // [R21]
  assign step_met  = start_c && ev_ok &&
                     (!has_count || tif.cis >= cnt_q[cur_ix]); // [R21]
  assign jog_rise  = HAS_EVENT && ctrl_q[CTRL_JOG] && !jog_prev_q; // [R3]
  assign at_last   = cur_q >= last_q;

  logic [SW-1:0] cur_d;
  logic          done_d;
  logic          clr_d;
  always_comb begin
    cur_d  = cur_q;
    done_d = done_q;
    clr_d  = 1'h0;
    if (entry) begin
      if (!retain) begin // [R12]
        cur_d  = preset_q; // [R11]
        done_d = 1'h0;
        clr_d  = 1'h1;
      end
    end else if (!run_f) begin
      cur_d = cur_q;
    end else if (rst_c) begin
      cur_d  = preset_q; // [R5]
      done_d = 1'h0; // [R18]
      clr_d  = 1'h1;
    end else if (!done_q && (jog_rise || step_met)) begin // [R23]
      clr_d = 1'h1; // [R19]
      if (at_last) begin
        done_d = 1'h1; // [R17] [R20]
      end else begin
        cur_d = cur_q + 1'h1; // [R3] [R21]
      end
    end
  end

  // timer runs only while start, event and target all allow it
  wire tick_run_d;
  assign tick_run_d = run_f && !entry && !rst_c && !done_d && start_c &&
                      ev_ok && has_count; // [R1] [R2] [R22]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cur_q      <= STEP_FIRST;
      preset_q   <= STEP_FIRST;
      done_q     <= 1'h0;
      jog_prev_q <= 1'h0;
      run_seen_q <= 1'h0;
      tick_run_q <= 1'h0;
    end else if (clk_en) begin
      if (scan_tick) begin
        cur_q      <= cur_d;
        done_q     <= done_d;
        jog_prev_q <= ctrl_q[CTRL_JOG];
        run_seen_q <= run_f;
        tick_run_q <= tick_run_d;
      end
      if (w_cur) cur_q <= w_step; // [R9]
      if (w_preset) preset_q <= w_step; // [R6]
    end
  end

  assign tif.clk_en   = clk_en;
  assign tif.tick_run = tick_run_q;
  assign tif.clear    = step_en && clr_d;
  assign tif.timebase = tbase_q;

  ssd_step_timer #(.TICK_N(TICK_N)) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tif     (tif)
  );

  // output image, masked write per bit
  wire [SW-1:0]   nxt_m1;
  wire [IW-1:0]   nxt_ix;
  wire [OUTS-1:0] wmask;
  wire [OUTS-1:0] out_d;
  assign nxt_m1 = cur_d - STEP_FIRST;
  assign nxt_ix = nxt_m1[IW-1:0];
  assign wmask  = MASKED ? msk_q[nxt_ix] : '1; // [R14]
  for (genvar b = 0; b < OUTS; b++) begin : g_out
    assign out_d[b] = wmask[b] ? pat_q[nxt_ix][b] : out_q[b]; // [R16]
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_q <= '0;
    end else if (step_en && run_f) begin
      out_q <= out_d; // [R10]
    end
  end
  assign out_image       = out_q;
  assign cycle_done_flag = done_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  wire quiet;
  assign quiet = step_en && run_f && !entry && !w_cur && !w_preset;

  sequence s_jog_last;
    quiet && !rst_c && !done_q && jog_rise && at_last;
  endsequence

  reset_hold_a: assert property ( // [R5]
    quiet && rst_c |=> cur_q == preset_q && !done_q && !tick_run_q)
    else $error("reset did not hold the preset step");

  done_clear_a: assert property ( // [R18]
    quiet && rst_c && done_q |=> !cycle_done_flag)
    else $error("reset left the done flag set");

  jog_step_a: assert property ( // [R3]
    quiet && !rst_c && !done_q && jog_rise && !at_last
    |=> cur_q == $past(cur_q) + 1'h1 && tif.tmr == '0)
    else $error("jog did not advance one step");

  jog_last_a: assert property ( // [R20]
    s_jog_last |=> done_q ##1 (done_q || $past(rst_c)))
    else $error("jog in last step did not complete");

  done_freeze_a: assert property ( // [R23]
    quiet && done_q && !rst_c |=> $stable(cur_q) && done_q)
    else $error("complete drum moved");

  stop_hold_a: assert property ( // [R2]
    quiet && !rst_c && !start_c && !jog_rise |=> $stable(cur_q))
    else $error("stopped drum changed step");

  mask_write_a: assert property ( // [R16]
    step_en && run_f |=> out_q == (($past(pat_q[nxt_ix]) & $past(wmask)) |
                                   ($past(out_q) & ~$past(wmask))))
    else $error("output image ignores the mask");

  nonret_entry_a: assert property ( // [R11]
    step_en && entry && !retain && !w_cur && !w_preset
    |=> cur_q == preset_q ##1 tif.cis == '0 && tif.tmr == '0)
    else $error("non-retentive entry did not initialise");

  ret_entry_a: assert property ( // [R12]
    step_en && entry && retain && !w_cur |=> $stable(cur_q))
    else $error("retentive entry changed the step");
endmodule : ssd_sequencer
`default_nettype wire

// ===== verilog/ssd_pkg.sv
// ssd_pkg: constants and types shared by the step sequencer drum files.
// assumes a 10 MHz system clock and AHB-Lite word access to the registers.
package ssd_pkg;
  localparam int unsigned STEPS         = 16;
  localparam int unsigned OUTS          = 16;
  localparam int unsigned CW            = 16;
  localparam int unsigned SW            = 5;
  localparam int unsigned IW            = 4;
  localparam int unsigned AW            = 12;
  localparam int unsigned SYNC_N        = 3;
  // hundredth-second tick
  localparam int unsigned TICK_US       = 10000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  // single registers
  localparam logic [AW-1:0] OFS_CTRL    = 12'h000;
  localparam logic [AW-1:0] OFS_STATUS  = 12'h004;
  localparam logic [AW-1:0] OFS_CIS     = 12'h008;
  localparam logic [AW-1:0] OFS_TMR     = 12'h00C;
  localparam logic [AW-1:0] OFS_PRESET  = 12'h010;
  localparam logic [AW-1:0] OFS_CUR     = 12'h014;
  localparam logic [AW-1:0] OFS_TBASE   = 12'h018;
  localparam logic [AW-1:0] OFS_LAST    = 12'h01C;
  localparam logic [AW-1:0] OFS_OUT     = 12'h020;
  // per-step tables, 16 words each
  localparam logic [AW-1:0] TAB_PAT     = 12'h040;
  localparam logic [AW-1:0] TAB_CNT     = 12'h080;
  localparam logic [AW-1:0] TAB_EVT     = 12'h0C0;
  localparam logic [AW-1:0] TAB_MSK     = 12'h100;
  localparam int unsigned   TAB_LSB     = 6;
  localparam int unsigned   IX_LSB      = 2;
  // field positions
  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_JOG      = 1;
  localparam int unsigned CTRL_RESET    = 2;
  localparam int unsigned CTRL_RETAIN   = 3;
  localparam int unsigned STAT_DONE     = 0;
  localparam int unsigned STAT_RUN      = 1;
  localparam int unsigned EVT_EN        = 4;
  // reset values
  localparam logic [SW-1:0] STEP_FIRST  = 5'h01;
  localparam logic [SW-1:0] STEP_LAST   = 5'h10;
  localparam logic          RETAIN_RST  = 1'h1;
  localparam logic [CW-1:0] TBASE_RST   = 16'h0001;
  localparam logic [1:0]    HTRANS_NSEQ = 2'h2;

  typedef enum {
    SSD_TIMED, SSD_TIME_EVENT, SSD_MASKED_BITS, SSD_MASKED_WORD
  } ssd_variant_t;
endpackage : ssd_pkg

// ===== verilog/ssd_timer_if.sv
// ssd_timer_if: link between the sequencer core and its step timer.
// assumes both ends sit on clk_sys.
`timescale 1ns/10ps
`default_nettype none
interface ssd_timer_if;
  import ssd_pkg::*;
  logic          clk_en;
  logic          tick_run;
  logic          clear;
  logic [CW-1:0] timebase;
  logic [CW-1:0] cis;
  logic [CW-1:0] tmr;
  modport seq (output clk_en, tick_run, clear, timebase, input cis, tmr);
  modport tmr_end (input clk_en, tick_run, clear, timebase,
                   output cis, tmr);
endinterface : ssd_timer_if
`default_nettype wire

// ===== verilog/ssd_step_timer.sv
// ssd_step_timer: hundredth-second prescaler, timer value, count in step.
// assumes the core holds tick_run as a level and pulses clear.
`timescale 1ns/10ps
`default_nettype none
module ssd_step_timer #(
  parameter int unsigned TICK_N = ssd_pkg::TICK_CYCLES
) (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  ssd_timer_if.tmr_end tif
);
  import ssd_pkg::*;
  localparam int unsigned PW = $clog2(TICK_N);

  logic [PW-1:0] pre_q;
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] cis_q;
  wire           tick;
  wire  [CW:0]   tmr_inc;
  wire           wrap;

  assign tick    = (pre_q == PW'(TICK_N - 1));
  assign tmr_inc = {1'h0, tmr_q} + 17'h00001;
  assign wrap    = (tmr_inc >= {1'h0, tif.timebase});
  assign tif.cis = cis_q;
  assign tif.tmr = tmr_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pre_q <= '0;
    end else if (tif.clk_en) begin
      pre_q <= tick ? '0 : pre_q + 1'h1;
    end
  end

  // timer in hundredths, count in step on each timebase wrap
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tmr_q <= '0;
      cis_q <= '0;
    end else if (tif.clk_en) begin
      if (tif.clear) begin
        tmr_q <= '0; // [R19]
        cis_q <= '0;
      end else if (tick && tif.tick_run) begin
        tmr_q <= wrap ? '0 : tmr_inc[CW-1:0]; // [R25]
        cis_q <= wrap ? cis_q + 1'h1 : cis_q; // [R25]
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  wrap_count_a: assert property ( // [R25]
    tif.clk_en && !tif.clear && tick && tif.tick_run && wrap
    |=> tmr_q == '0 && cis_q == $past(cis_q) + 1'h1)
    else $error("timebase wrap did not bump count in step");

  idle_hold_a: assert property ( // [R2]
    tif.clk_en && !tif.clear && !tif.tick_run
    |=> $stable(tmr_q) && $stable(cis_q))
    else $error("timer moved while stopped");
endmodule : ssd_step_timer
`default_nettype wire

// ===== sim/ssd_ladder_model.sv
// ssd_ladder_model: stand-in for the ladder logic that drives the drum pins.
// assumes the bench requests run mode and event points as levels.
`timescale 1ns/10ps
`default_nettype none
module ssd_ladder_model (
  input  wire logic        clk_sys,
  input  wire logic        run_req,
  input  wire logic [15:0] evt_req,
  output logic             run_mode_pin,
  output logic [15:0]      event_pin
);
  initial begin
    run_mode_pin = 1'b0;
    event_pin    = 16'h0000;
  end
  // pins move only just after an edge, like a scan writing its image
  always @(posedge clk_sys) begin
    run_mode_pin <= run_req;
    event_pin    <= evt_req;
  end
endmodule : ssd_ladder_model
`default_nettype wire

// ===== sim/testbench.sv
// testbench: register-level tests of the step sequencer drum.
// assumes ssd_pkg, ssd_sequencer and the ladder model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  err_count++; $display("mismatch %s expected %h seen %h", nm, ex, gt); \
  end end
module testbench;
  import ssd_pkg::*;
  localparam int unsigned TN = 4;
  logic        clk_sys, reset, clk_en, scan_tick, hsel, hwrite, run_req;
  logic        hreadyout, hresp, cycle_done_flag, run_mode_pin, rdy_s;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, hr_s;
  logic [15:0] evt_req, event_pin, out_image;
  int          err_count, tests_run;

  ssd_sequencer #(.VARIANT(SSD_MASKED_WORD), .TICK_N(TN)) dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .scan_tick(scan_tick), .run_mode_pin(run_mode_pin),
    .event_pin(event_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .out_image(out_image), .cycle_done_flag(cycle_done_flag));

  ssd_ladder_model ladder (
    .clk_sys(clk_sys), .run_req(run_req), .evt_req(evt_req),
    .run_mode_pin(run_mode_pin), .event_pin(event_pin));

  always #50 clk_sys = ~clk_sys;
  // values as seen at each rising edge
  always @(posedge clk_sys) begin
    rdy_s <= hreadyout;
    hr_s  <= hrdata;
  end

  task give_verdict();
    $display("counts: comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (rdy_s !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_rdy

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic ahb_write(input logic [11:0] a, input logic [15:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_rdy();
  endtask : ahb_write

  task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = hr_s;
  endtask : ahb_read

  task automatic chk_reg(input string nm, input logic [11:0] a,
                         input logic [31:0] ex);
    logic [31:0] v;
    ahb_read(a, v);
    `CHK(nm, ex, v)
  endtask : chk_reg

  task automatic wait_cur(input logic [31:0] ex);
    logic [31:0] v;
    int          n;
    n = 0;
    do begin
      ahb_read(OFS_CUR, v);
      n++;
    end while (v !== ex && n < 100);
    `CHK("current step", ex, v)
  endtask : wait_cur

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    scan_tick = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run_req = 1'b0;
    evt_req = 16'h0000;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    idle(1);
    // reset values and an unmapped word
    chk_reg("ctrl", OFS_CTRL, 32'h8);
    chk_reg("status", OFS_STATUS, 32'h0);
    chk_reg("count", OFS_CIS, 32'h0);
    chk_reg("timer", OFS_TMR, 32'h0);
    chk_reg("preset", OFS_PRESET, 32'h1);
    chk_reg("current", OFS_CUR, 32'h1);
    chk_reg("unmapped", 12'h3FC, 32'h0);
    `CHK("okay resp", 1'b0, hresp)
    $display("test done: reset values");
    // tables: pattern n*1111, one count except step 2 none and step 3 two, step 2 waits on event 5
    for (int i = 0; i < 16; i++) begin
      ahb_write(TAB_PAT + 12'(4 * i), 16'(i + 1) * 16'h1111);
      ahb_write(TAB_CNT + 12'(4 * i), (i == 1) ? 16'h0000 : 16'h0001);
    end
    ahb_write(TAB_EVT + 12'h004, 16'h0015);
    ahb_write(TAB_CNT + 12'h008, 16'h0002);
    ahb_write(OFS_TBASE, 16'h0002);
    ahb_write(OFS_CTRL, 16'h0000);
    ahb_write(OFS_PRESET, 16'h0002);
    ahb_write(OFS_PRESET, 16'h0011);
    ahb_write(OFS_LAST, 16'h0004);
    chk_reg("preset range", OFS_PRESET, 32'h2);
    run_req <= 1'b1;
    idle(20);
    chk_reg("entry step", OFS_CUR, 32'h2);
    chk_reg("entry count", OFS_CIS, 32'h0);
    chk_reg("entry image", OFS_OUT, 32'h2222);
    `CHK("out pins", 16'h2222, out_image)
    $display("test done: non-retentive entry");
    idle(20);
    chk_reg("held step", OFS_CUR, 32'h2);
    ahb_write(OFS_CTRL, 16'h0002);
    ahb_write(OFS_CTRL, 16'h0000);
    idle(5);
    chk_reg("jog step", OFS_CUR, 32'h3);
    chk_reg("jog timer", OFS_TMR, 32'h0);
    `CHK("jog pins", 16'h3333, out_image)
    $display("test done: hold and jog");
    // step 3: two counts of two hundredths
    ahb_write(OFS_CTRL, 16'h0001);
    idle(6);
    chk_reg("early step", OFS_CUR, 32'h3);
    wait_cur(32'h4);
    for (int n = 0; n < 100 && cycle_done_flag !== 1'b1; n++) idle(1);
    `CHK("done pin", 1'b1, cycle_done_flag)
    chk_reg("last step", OFS_CUR, 32'h4);
    chk_reg("done status", OFS_STATUS, 32'h3);
    ahb_write(OFS_CTRL, 16'h0003);
    ahb_write(OFS_CTRL, 16'h0001);
    idle(5);
    chk_reg("done jog", OFS_CUR, 32'h4);
    `CHK("done image", 16'h4444, out_image)
    $display("test done: timed run to complete");
    ahb_write(OFS_CTRL, 16'h0005);
    idle(5);
    `CHK("reset done", 1'b0, cycle_done_flag)
    chk_reg("reset step", OFS_CUR, 32'h2);
    idle(30);
    chk_reg("reset hold", OFS_CUR, 32'h2);
    $display("test done: reset control");
    // step 3 masked to low byte and waiting on a quiet event
    ahb_write(TAB_MSK + 12'h008, 16'h00FF);
    ahb_write(TAB_EVT + 12'h008, 16'h0016);
    ahb_write(OFS_CTRL, 16'h0001);
    idle(30);
    chk_reg("event wait", OFS_CUR, 32'h2);
    evt_req <= 16'h0020;
    wait_cur(32'h3);
    `CHK("mask pins", 16'h2233, out_image)
    idle(30);
    chk_reg("event low", OFS_CUR, 32'h3);
    $display("test done: events and mask");
    ahb_write(OFS_CTRL, 16'h0008);
    run_req <= 1'b0;
    idle(20);
    run_req <= 1'b1;
    idle(20);
    chk_reg("kept step", OFS_CUR, 32'h3);
    chk_reg("kept preset", OFS_PRESET, 32'h2);
    $display("test done: retentive entry");
    // software step write, then jog out of the last step
    ahb_write(OFS_CUR, 16'h0004);
    chk_reg("written step", OFS_CUR, 32'h4);
    `CHK("written pins", 16'h4444, out_image)
    ahb_write(OFS_CTRL, 16'h000A);
    ahb_write(OFS_CTRL, 16'h0008);
    idle(5);
    `CHK("jog done", 1'b1, cycle_done_flag)
    chk_reg("jog last", OFS_CUR, 32'h4);
    $display("test done: jog out of last step");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
